// *** scrb_pkg.sv ***
package scrb_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 12;
   localparam logic [4:0] BIT_CNT_FULL = 5'h10;
   localparam logic [4:0] BIT_CNT_RST  = 5'h00;

   localparam logic [3:0] OFS_POWER_SUM  = 4'h0;
   localparam logic [3:0] OFS_MODE_SEL   = 4'h1;
   localparam logic [3:0] OFS_RF_GAINS   = 4'h3;
   localparam logic [3:0] OFS_RF_OFFS    = 4'h4;
   localparam logic [3:0] OFS_SUM_OFFS   = 4'h5;
   localparam logic [3:0] OFS_SERVO_BAL  = 4'h6;
   localparam logic [3:0] OFS_PH_LEGACY  = 4'h7;
   localparam logic [3:0] OFS_SERVO_OFFS = 4'hB;
   localparam logic [3:0] OFS_RF_BW      = 4'hE;
   localparam logic [3:0] OFS_PH_EXT     = 4'hF;

   localparam logic [11:0] REG_RST = 12'h000;
   localparam logic [6:0]  BW_MIN  = 7'h00;

   // field positions
   localparam int POS_POWER_ON_CONTROL    = 0;
   localparam int POS_SUM_GAIN = 5;
   localparam int POS_SUM_SEL  = 0;
   localparam int POS_DOC_EN   = 5;
   localparam int POS_PH_SRC   = 11;
   localparam int POS_G1       = 10;
   localparam int POS_G2       = 8;
   localparam int POS_G3       = 4;
   localparam int POS_L_OFFS   = 6;
   localparam int POS_COARSE   = 10;
   localparam int POS_RAD_E    = 4;
   localparam int POS_COMPAT   = 11;
   localparam int POS_RANGE    = 11;
   localparam int POS_PE_EXT   = 3;
endpackage : scrb_pkg

// *** scrb_sync.sv ***
module scrb_sync
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   logic meta_r;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_r <= 1'b0;
         dout   <= 1'b0;
      end
      else
      begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule : scrb_sync

// *** scrb_shift.sv ***
// collects serial bits; only this shift register and its bit count change during a transfer
module scrb_shift
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        sclk_rise,
   input  wire logic        sda,
   input  wire logic        ld,
   output logic [15:0]      shift_r,
   output logic [4:0]       count_r
);
   always_ff @(posedge clk)
   begin
      if (rst)
         shift_r <= 16'h0000;
      else if (sclk_rise && !ld)
         shift_r <= {shift_r[14:0], sda};
   end

   always_ff @(posedge clk)
   begin
      if (rst || ld)
         count_r <= scrb_pkg::BIT_CNT_RST;
      else if (sclk_rise && count_r != 5'h1F)
         count_r <= count_r + 5'h01;
   end
endmodule : scrb_shift

// *** scrb_top.sv ***
module scrb_top
(
   input  wire logic        MCLK,
   input  wire logic        SYS_RST,
   input  wire logic        SERIAL_DATA_LINE,
   input  wire logic        SERIAL_CLOCK_LINE,
   input  wire logic        LOAD_STROBE,
   output logic             POWER_ON_CONTROL,
   output logic [2:0]       SUMMED_INPUT_GAIN,
   output logic [4:0]       LASER_MONITOR_CTRL,
   output logic             SUMMED_INPUT_SELECT,
   output logic             DROPOUT_CONCEAL_ENABLE,
   output logic             PHASE_OFFSET_SOURCE,
   output logic             COMPAT_MODE_BIT,
   output logic [1:0]       FIRST_STAGE_GAIN,
   output logic [1:0]       SECOND_STAGE_GAIN,
   output logic [3:0]       THIRD_STAGE_GAIN,
   output logic [5:0]       LEFT_RF_OFFSET_CODE,
   output logic [5:0]       RIGHT_RF_OFFSET_CODE,
   output logic [5:0]       SUMMED_PATH_OFFSET_CODE,
   output logic [5:0]       PHASE_RF_OFFSET_CODE,
   output logic [3:0]       BALANCE_FACTOR,
   output logic [1:0]       PREEMPHASIS_LEGACY,
   output logic [2:0]       PREEMPHASIS_START_FREQ,
   output logic [1:0]       COARSE_SERVO_OFFSET,
   output logic [3:0]       RADIAL_E_OFFSET,
   output logic [3:0]       RADIAL_F_OFFSET,
   output logic             SERVO_OFFSET_RANGE,
   output logic [6:0]       RF_BANDWIDTH_CODE
);
   logic        sda_s;
   logic        scl_s;
   logic        ld_s;
   logic        scl_d_r;
   logic        ld_d_r;
   logic        sclk_rise;
   logic        ld_rise;
   logic [15:0] shift_r;
   logic [4:0]  count_r;
   logic [3:0]  addr;
   logic [11:0] data;
   logic        commit;

   scrb_sync u_sda (.clk(MCLK), .rst(SYS_RST), .din(SERIAL_DATA_LINE), .dout(sda_s));
   scrb_sync u_scl (.clk(MCLK), .rst(SYS_RST), .din(SERIAL_CLOCK_LINE), .dout(scl_s));
   scrb_sync u_ld  (.clk(MCLK), .rst(SYS_RST), .din(LOAD_STROBE), .dout(ld_s));

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         scl_d_r <= 1'b0;
         ld_d_r  <= 1'b1;
      end
      else
      begin
         scl_d_r <= scl_s;
         ld_d_r  <= ld_s;
      end
   end

   // data is stable while clock high, so equal sync delay keeps them aligned
   assign sclk_rise = scl_s && !scl_d_r;
   assign ld_rise   = ld_s && !ld_d_r;

   scrb_shift u_shift
   (
      .clk      (MCLK),
      .rst      (SYS_RST),
      .sclk_rise(sclk_rise),
      .sda      (sda_s),
      .ld       (ld_s),
      .shift_r  (shift_r),
      .count_r  (count_r)
   );

   assign addr   = shift_r[15:12];
   assign data   = shift_r[11:0];
   // extra clocks beyond 16 keep the last 16 bits; fewer are discarded
   assign commit = ld_rise && (count_r >= scrb_pkg::BIT_CNT_FULL);

   // register images, one per mapped address
   logic [11:0] r0_r;
   logic [11:0] r1_r;
   logic [11:0] r3_r;
   logic [11:0] r4_r;
   logic [11:0] r5_r;
   logic [11:0] r6_r;
   logic [11:0] r7_r;
   logic [11:0] r11_r;
   logic [11:0] r14_r;
   logic [11:0] r15_r;

   // one write decoder shared by every register image
   function automatic logic wr_hit(input logic go, input logic [3:0] a, input logic [3:0] ofs);
      return go && (a == ofs);
   endfunction : wr_hit

   // source mux shared by the summed and phase-detector offset paths
   function automatic logic [5:0] pick_offset(input logic       src,
                                              input logic [5:0] alt,
                                              input logic [5:0] base);
      return src ? alt : base;
   endfunction : pick_offset

   // unmapped addresses match no image, so their words fall away
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         r0_r <= scrb_pkg::REG_RST;
      else if (wr_hit(commit, addr, scrb_pkg::OFS_POWER_SUM))
         r0_r <= data;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         r1_r <= scrb_pkg::REG_RST;
      else if (wr_hit(commit, addr, scrb_pkg::OFS_MODE_SEL))
         r1_r <= data;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         r3_r <= scrb_pkg::REG_RST;
      else if (wr_hit(commit, addr, scrb_pkg::OFS_RF_GAINS))
         r3_r <= data;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         r4_r <= scrb_pkg::REG_RST;
      else if (wr_hit(commit, addr, scrb_pkg::OFS_RF_OFFS))
         r4_r <= data;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         r5_r <= scrb_pkg::REG_RST;
      else if (wr_hit(commit, addr, scrb_pkg::OFS_SUM_OFFS))
         r5_r <= data;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         r6_r <= scrb_pkg::REG_RST;
      else if (wr_hit(commit, addr, scrb_pkg::OFS_SERVO_BAL))
         r6_r <= data;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         r7_r <= scrb_pkg::REG_RST;
      else if (wr_hit(commit, addr, scrb_pkg::OFS_PH_LEGACY))
         r7_r <= data;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         r11_r <= scrb_pkg::REG_RST;
      else if (wr_hit(commit, addr, scrb_pkg::OFS_SERVO_OFFS))
         r11_r <= data;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         r14_r <= scrb_pkg::REG_RST;
      else if (wr_hit(commit, addr, scrb_pkg::OFS_RF_BW))
         r14_r <= data;
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         r15_r <= scrb_pkg::REG_RST;
      else if (wr_hit(commit, addr, scrb_pkg::OFS_PH_EXT))
         r15_r <= data;
   end

   // decoded fields registered once more so every output is a flop
   logic compat;
   logic sum_sel;
   logic ph_src;
   assign compat  = r15_r[scrb_pkg::POS_COMPAT];
   assign sum_sel = r1_r[scrb_pkg::POS_SUM_SEL];
   assign ph_src  = r1_r[scrb_pkg::POS_PH_SRC];

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         POWER_ON_CONTROL   <= 1'b0;
         SUMMED_INPUT_GAIN  <= 3'h0;
         LASER_MONITOR_CTRL <= 5'h00;
      end
      else
      begin
         POWER_ON_CONTROL   <= r0_r[scrb_pkg::POS_POWER_ON_CONTROL];
         SUMMED_INPUT_GAIN  <= r0_r[scrb_pkg::POS_SUM_GAIN +: 3];
         LASER_MONITOR_CTRL <= {1'b0, r0_r[4:1]};
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         SUMMED_INPUT_SELECT    <= 1'b0;
         DROPOUT_CONCEAL_ENABLE <= 1'b0;
         PHASE_OFFSET_SOURCE    <= 1'b0;
      end
      else
      begin
         SUMMED_INPUT_SELECT    <= sum_sel;
         DROPOUT_CONCEAL_ENABLE <= r1_r[scrb_pkg::POS_DOC_EN];
         PHASE_OFFSET_SOURCE    <= ph_src;
      end
   end

   // legacy mode pins the extended fields at their predecessor values
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         COMPAT_MODE_BIT        <= 1'b0;
         PREEMPHASIS_START_FREQ <= 3'h0;
         RF_BANDWIDTH_CODE      <= scrb_pkg::BW_MIN;
      end
      else
      begin
         COMPAT_MODE_BIT        <= compat;
         PREEMPHASIS_START_FREQ <= compat ? r15_r[scrb_pkg::POS_PE_EXT +: 3] : 3'h0;
         RF_BANDWIDTH_CODE      <= compat ? r14_r[6:0] : scrb_pkg::BW_MIN;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         FIRST_STAGE_GAIN  <= 2'h0;
         SECOND_STAGE_GAIN <= 2'h0;
         THIRD_STAGE_GAIN  <= 4'h0;
      end
      else
      begin
         FIRST_STAGE_GAIN  <= r3_r[scrb_pkg::POS_G1 +: 2];
         SECOND_STAGE_GAIN <= r3_r[scrb_pkg::POS_G2 +: 2];
         THIRD_STAGE_GAIN  <= r3_r[scrb_pkg::POS_G3 +: 4];
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         LEFT_RF_OFFSET_CODE     <= 6'h00;
         RIGHT_RF_OFFSET_CODE    <= 6'h00;
         SUMMED_PATH_OFFSET_CODE <= 6'h00;
         PHASE_RF_OFFSET_CODE    <= 6'h00;
      end
      else
      begin
         LEFT_RF_OFFSET_CODE     <= r4_r[scrb_pkg::POS_L_OFFS +: 6];
         RIGHT_RF_OFFSET_CODE    <= r4_r[5:0];
         SUMMED_PATH_OFFSET_CODE <= pick_offset(ph_src, r5_r[5:0], r4_r[5:0]);
         PHASE_RF_OFFSET_CODE    <= pick_offset(ph_src, r5_r[5:0],
                                                r4_r[scrb_pkg::POS_L_OFFS +: 6]);
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         BALANCE_FACTOR     <= 4'h0;
         PREEMPHASIS_LEGACY <= 2'h0;
      end
      else
      begin
         BALANCE_FACTOR     <= r6_r[3:0];
         PREEMPHASIS_LEGACY <= r7_r[1:0];
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         COARSE_SERVO_OFFSET <= 2'h0;
         RADIAL_E_OFFSET     <= 4'h0;
         RADIAL_F_OFFSET     <= 4'h0;
         SERVO_OFFSET_RANGE  <= 1'b0;
      end
      else
      begin
         COARSE_SERVO_OFFSET <= r11_r[scrb_pkg::POS_COARSE +: 2];
         RADIAL_E_OFFSET     <= r11_r[scrb_pkg::POS_RAD_E +: 4];
         RADIAL_F_OFFSET     <= r11_r[3:0];
         SERVO_OFFSET_RANGE  <= r14_r[scrb_pkg::POS_RANGE];
      end
   end
endmodule : scrb_top

// *** scrb_props.sv ***
module scrb_props
(
   input wire logic       MCLK,
   input wire logic       SYS_RST,
   input wire logic       LOAD_STROBE,
   input wire logic       POWER_ON_CONTROL,
   input wire logic       PHASE_OFFSET_SOURCE,
   input wire logic       COMPAT_MODE_BIT,
   input wire logic [5:0] LEFT_RF_OFFSET_CODE,
   input wire logic [5:0] RIGHT_RF_OFFSET_CODE,
   input wire logic [5:0] SUMMED_PATH_OFFSET_CODE,
   input wire logic [5:0] PHASE_RF_OFFSET_CODE,
   input wire logic [3:0] BALANCE_FACTOR,
   input wire logic [2:0] PREEMPHASIS_START_FREQ,
   input wire logic [3:0] RADIAL_F_OFFSET,
   input wire logic [6:0] RF_BANDWIDTH_CODE
);
   logic [44:0] outs;
   logic [2:0]  lo_cnt_r;
   logic [2:0]  hi_cnt_r;
   assign outs = {POWER_ON_CONTROL, PHASE_OFFSET_SOURCE, COMPAT_MODE_BIT, LEFT_RF_OFFSET_CODE,
      RIGHT_RF_OFFSET_CODE, SUMMED_PATH_OFFSET_CODE, PHASE_RF_OFFSET_CODE, BALANCE_FACTOR,
      PREEMPHASIS_START_FREQ, RADIAL_F_OFFSET, RF_BANDWIDTH_CODE};
   // saturating run lengths of the strobe level, past the commit latency
   always_ff @(posedge MCLK)
   begin
      lo_cnt_r <= (SYS_RST || LOAD_STROBE) ? 3'h0 : lo_cnt_r + {2'h0, lo_cnt_r != 3'h7};
      hi_cnt_r <= (SYS_RST || !LOAD_STROBE) ? 3'h0 : hi_cnt_r + {2'h0, hi_cnt_r != 3'h7};
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   property p_reset_clears; $fell(SYS_RST) |-> outs == 45'h0; endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("not cleared");
   property p_hi_quiet; hi_cnt_r == 3'h7 |-> $stable(outs); endproperty
   a_hi_quiet: assert property (p_hi_quiet) else $error("change while idle");
   property p_lo_quiet; lo_cnt_r == 3'h7 |-> $stable(outs); endproperty
   a_lo_quiet: assert property (p_lo_quiet) else $error("change mid transfer");
   property p_commit; !$stable(outs) |-> $past(LOAD_STROBE,4) && !$past(LOAD_STROBE,7); endproperty
   a_commit: assert property (p_commit) else $error("change off strobe");
   property p_bw_legacy; !COMPAT_MODE_BIT |-> RF_BANDWIDTH_CODE == 7'h00; endproperty
   a_bw_legacy: assert property (p_bw_legacy) else $error("bandwidth not min");
   property p_pe_legacy; !COMPAT_MODE_BIT |-> PREEMPHASIS_START_FREQ == 3'h0; endproperty
   a_pe_legacy: assert property (p_pe_legacy) else $error("extended field live");
   property p_src_sum; PHASE_OFFSET_SOURCE |-> SUMMED_PATH_OFFSET_CODE == PHASE_RF_OFFSET_CODE;
   endproperty
   a_src_sum: assert property (p_src_sum) else $error("offset source wrong");
   property p_src_split; !PHASE_OFFSET_SOURCE |-> PHASE_RF_OFFSET_CODE == LEFT_RF_OFFSET_CODE
      && SUMMED_PATH_OFFSET_CODE == RIGHT_RF_OFFSET_CODE; endproperty
   a_src_split: assert property (p_src_split) else $error("offset split wrong");
endmodule : scrb_props

bind scrb_top scrb_props i_scrb_props
(
   .MCLK(MCLK), .SYS_RST(SYS_RST), .LOAD_STROBE(LOAD_STROBE), .POWER_ON_CONTROL(POWER_ON_CONTROL),
   .PHASE_OFFSET_SOURCE(PHASE_OFFSET_SOURCE), .COMPAT_MODE_BIT(COMPAT_MODE_BIT),
   .LEFT_RF_OFFSET_CODE(LEFT_RF_OFFSET_CODE), .RIGHT_RF_OFFSET_CODE(RIGHT_RF_OFFSET_CODE),
   .SUMMED_PATH_OFFSET_CODE(SUMMED_PATH_OFFSET_CODE), .BALANCE_FACTOR(BALANCE_FACTOR),
   .PHASE_RF_OFFSET_CODE(PHASE_RF_OFFSET_CODE), .RADIAL_F_OFFSET(RADIAL_F_OFFSET),
   .PREEMPHASIS_START_FREQ(PREEMPHASIS_START_FREQ), .RF_BANDWIDTH_CODE(RF_BANDWIDTH_CODE)
);

// *** scrb_host.sv ***
module scrb_host
(
   output logic sda,
   output logic scl,
   output logic ld
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      sda = 1'b0;
      scl = 1'b0;
      ld = 1'b1;
   end
   // link clock stands low outside frames, except while noise() toggles it with the strobe high
   task automatic send(input logic [31:0] w, input int n);
      #0.3; // keeps every pin edge off the MCLK edges, so latency is exact
      ld = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sda = w[i];
         #62.5 scl = 1'b1;
         #62.5 scl = 1'b0;
      end
      #62.5 ld = 1'b1;
      sda = ~sda;
      #62.5;
   endtask : send
   task automatic noise(input logic [7:0] p);
      for (int i = 0; i < 8; i++)
      begin
         sda = p[i];
         #40 scl = 1'b1;
         #40 scl = 1'b0;
      end
   endtask : noise
endmodule : scrb_host

// *** scrb_bench.sv ***
module scrb_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   wire logic   sda;
   wire logic   scl;
   wire logic   ld;
   wire logic [71:0] d;
   logic [11:0] r [16];
   logic [31:0] seed = 32'h5A2A;
   int          err_total = 0;
   int          comparisons = 0;
   int          n;
   always #4 mclk = ~mclk;
   scrb_host i_scrb_host (.sda(sda), .scl(scl), .ld(ld));
   scrb_top i_scrb_top
   (
      .MCLK(mclk), .SYS_RST(sys_rst), .SERIAL_DATA_LINE(sda), .SERIAL_CLOCK_LINE(scl),
      .LOAD_STROBE(ld), .POWER_ON_CONTROL(d[71]), .SUMMED_INPUT_GAIN(d[70:68]),
      .LASER_MONITOR_CTRL(d[67:63]), .SUMMED_INPUT_SELECT(d[62]),
      .DROPOUT_CONCEAL_ENABLE(d[61]), .PHASE_OFFSET_SOURCE(d[60]), .COMPAT_MODE_BIT(d[59]),
      .FIRST_STAGE_GAIN(d[58:57]), .SECOND_STAGE_GAIN(d[56:55]), .THIRD_STAGE_GAIN(d[54:51]),
      .LEFT_RF_OFFSET_CODE(d[50:45]), .RIGHT_RF_OFFSET_CODE(d[44:39]),
      .SUMMED_PATH_OFFSET_CODE(d[38:33]), .PHASE_RF_OFFSET_CODE(d[32:27]),
      .BALANCE_FACTOR(d[26:23]), .PREEMPHASIS_LEGACY(d[22:21]),
      .PREEMPHASIS_START_FREQ(d[20:18]), .COARSE_SERVO_OFFSET(d[17:16]),
      .RADIAL_E_OFFSET(d[15:12]), .RADIAL_F_OFFSET(d[11:8]), .SERVO_OFFSET_RANGE(d[7]),
      .RF_BANDWIDTH_CODE(d[6:0])
   );
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic [71:0] expect_out();
      logic c;
      c = r[15][11];
      return {r[0][0], r[0][7:5], 1'b0, r[0][4:1], r[1][0], r[1][5], r[1][11], c, r[3][11:4],
         r[4], (r[1][11] ? r[5][5:0] : r[4][5:0]), (r[1][11] ? r[5][5:0] : r[4][11:6]),
         r[6][3:0], r[7][1:0], (c ? r[15][5:3] : 3'h0), r[11][11:10], r[11][7:0], r[14][11],
         (c ? r[14][6:0] : 7'h00)};
   endfunction : expect_out
   task automatic check(input string name, input logic [71:0] exp, input logic [71:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic report_and_stop();
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // unmapped addresses and short words leave the model untouched; long words keep the tail
   task automatic write(input logic [31:0] w, input int k);
      i_scrb_host.send(w, k);
      if (k >= 16 && w[15:12] inside {4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hE, 4'hF})
         r[w[15:12]] = w[11:0];
      @(negedge mclk);
      check("outputs", expect_out(), d);
   endtask : write
   task automatic restart();
      foreach (r[i])
         r[i] = 12'h000;
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check("reset", 72'h0, d);
   endtask : restart
   initial
   begin
      restart();
      write(32'h3FFF, 16);
      for (int a = 0; a < 16; a++)
      begin
         seed = xs(seed);
         write({16'h0000, a[3:0], seed[11:0]}, 16);
      end
      write(32'hF828, 16);
      write(32'hE87F, 16);
      write(32'hF000, 16);
      write(32'h1801, 16);
      write(32'h1000, 16);
      for (int t = 0; t < 120; t++)
      begin
         seed = xs(seed);
         if (seed[25])
            i_scrb_host.noise(seed[7:0]);
         n = seed[20] ? 16 : 8 + int'(seed[24:21]);
         seed = xs(seed);
         write(seed, n);
      end
      restart();
      write(32'h0001, 16);
      report_and_stop();
   end
   initial
   begin
      #500000;
      err_total++;
      report_and_stop();
   end
endmodule : scrb_bench
